/* File: hw/sle_core.sv */
// Executor for no-op, OR, system push/pop, user stack push/pop and
// threaded dispatch. Holds the register file, stack pointer and flags.
// Assumes synchronous memories: read data valid the cycle after the
// registered read strobe is seen.
//
// Contract
// - The no-operation opcode FF changes nothing and only uses time.
// - No-op, push, pop and the four user stack moves keep all flags.
// - OR writes dst OR src into dst and leaves the source alone.
// - OR sets Z on zero, S from bit 7, clears V, keeps C, D and H.
// - Pop (50, 8 cycles) loads dst from the top then bumps SP up.
// - Push (70, 8 cycles) drops SP by one then writes at the new SP.
// - SP is one 16-bit value over two bytes, wrapping 0 to FFFF.
// - Decrementing user pop loads dst via the pointer then drops it.
// - Incrementing user pop loads dst via the pointer then bumps it.
// - Decrementing user push drops the pointer then stores src.
// - Incrementing user push bumps the pointer then stores src.
// - Dispatch loads PC from the word at the IP, then adds two to IP.
`timescale 1ns/1ps
`include "sle_consts.svh"
module sle_core (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire sle_pkg::sle_cmd_s cmd_i,
   input wire sle_pkg::sle_wr_s host_wr_i,
   input wire logic [7:0] dbg_addr_i,
   input wire logic [7:0] mem_rdata_i,
   input wire logic [15:0] prog_rdata_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] dbg_data_o,
   output logic [7:0] flags_o,
   output logic [15:0] pc_o,
   output sle_pkg::sle_mem_s mem_o,
   output logic prog_re_o,
   output logic [15:0] prog_addr_o
);
   ////////////////////////////////////////////////////////////////////
   logic rst_s1_r;
   logic rst_n;
   logic [7:0] rf_q [256];
   sle_pkg::sle_cmd_s cmd_r;
   sle_pkg::sle_state_e state_r;
   logic [3:0] step_r;
   logic busy_r;
   logic done_r;
   logic [7:0] dbg_r;
   logic [15:0] pc_r;
   sle_pkg::sle_mem_s mem_r;
   logic prog_re_r;
   logic [15:0] prog_addr_r;
   logic [7:0] flg_start_r;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decode
   wire [7:0] op = cmd_r.opcode;
   wire run = busy_r;
   wire is_or = run && (op == `SLE_OP_OR);
   wire is_pop = run && (op == `SLE_OP_POP);
   wire is_push = run && (op == `SLE_OP_PUSH);
   wire is_next = run && (op == `SLE_OP_NEXT);
   wire is_upop = run && (op == `SLE_OP_UPOPD || op == `SLE_OP_UPOPI);
   wire is_upsh = run && (op == `SLE_OP_UPSHD || op == `SLE_OP_UPSHI);
   wire usp_up = (op == `SLE_OP_UPOPI) || (op == `SLE_OP_UPSHI);
   wire [3:0] cyc_total = (op == `SLE_OP_OR) ? `SLE_CYC_OR :
                          (op == `SLE_OP_NEXT) ? `SLE_CYC_NEXT :
                          (is_pop || is_push || is_upop || is_upsh) ?
                          `SLE_CYC_STK : `SLE_CYC_NOP;
   wire last = (step_r == cyc_total - 4'h1);
   wire [7:0] flg = rf_q[`SLE_ADR_FLG];
   wire [15:0] sp_cur = {rf_q[`SLE_ADR_SPH], rf_q[`SLE_ADR_SPL]};
   wire [15:0] ip_cur = {rf_q[`SLE_ADR_IPH], rf_q[`SLE_ADR_IPL]};
   wire [7:0] src_val = cmd_r.src_imm ? cmd_r.src : rf_q[cmd_r.src];
   wire [7:0] or_res = rf_q[cmd_r.dst] | src_val;
   wire [7:0] or_flg = (flg & ~`SLE_ZSV_MASK) |
                       ({7'h00, or_res == 8'h00} << `SLE_FLG_Z) |
                       ({7'h00, or_res[7]} << `SLE_FLG_S);
   wire [7:0] usp_adr = is_upop ? cmd_r.src : cmd_r.dst;
   wire [7:0] usp_val = rf_q[usp_adr];
   wire [15:0] sp_nxt;
   wire [7:0] usp_nxt;
   wire [15:0] ip_nxt;
   sle_step #(.W(16), .STEP(1)) u_sp_step (
      .val_i(sp_cur),
      .up_i(is_pop),
      .val_o(sp_nxt)
   );
   sle_step #(.W(8), .STEP(1)) u_usp_step (
      .val_i(usp_val),
      .up_i(usp_up),
      .val_o(usp_nxt)
   );
   sle_step #(.W(16), .STEP(2)) u_ip_step (
      .val_i(ip_cur),
      .up_i(1'b1),
      .val_o(ip_nxt)
   );

   ////////////////////////////////////////////////////////////////////
   // Register file write ports
   logic we0;
   logic we1;
   logic [7:0] wa0;
   logic [7:0] wa1;
   logic [7:0] wd0;
   logic [7:0] wd1;
   always_comb
   begin
      we0 = 1'b0;
      we1 = 1'b0;
      wa0 = cmd_r.dst;
      wa1 = `SLE_ADR_FLG;
      wd0 = 8'h00;
      wd1 = 8'h00;
      if (is_or && step_r == 4'h0)
      begin
         {we0, wd0} = {1'b1, or_res};
         {we1, wd1} = {1'b1, or_flg};
      end
      else if (is_pop && step_r == 4'h2)
         {we0, wd0} = {1'b1, mem_rdata_i};
      else if ((is_pop && step_r == 4'h3) || (is_push && step_r == 4'h0))
      begin
         {we0, wa0, wd0} = {1'b1, `SLE_ADR_SPL, sp_nxt[7:0]};
         {we1, wa1, wd1} = {1'b1, `SLE_ADR_SPH, sp_nxt[15:8]};
      end
      // read through the pointer, then step it
      else if (is_upop && step_r == 4'h0)
         {we0, wd0} = {1'b1, rf_q[usp_val]};
      else if ((is_upop && step_r == 4'h1) || (is_upsh && step_r == 4'h0))
         {we0, wa0, wd0} = {1'b1, usp_adr, usp_nxt};
      else if (is_upsh && step_r == 4'h1)
         {we0, wa0, wd0} = {1'b1, usp_val, src_val};
      else if (is_next && step_r == 4'h3)
      begin
         {we0, wa0, wd0} = {1'b1, `SLE_ADR_IPL, ip_nxt[7:0]};
         {we1, wa1, wd1} = {1'b1, `SLE_ADR_IPH, ip_nxt[15:8]};
      end
      else if (!busy_r && host_wr_i.we)
         {we0, wa0, wd0} = {1'b1, host_wr_i.addr, host_wr_i.data};
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 256; i++)
            rf_q[i] <= `SLE_RST_BYTE;
      end
      else
      begin
         if (we0)
            rf_q[wa0] <= wd0;
         if (we1)
            rf_q[wa1] <= wd1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= sle_pkg::SLE_IDLE;
         cmd_r <= '0;
         step_r <= 4'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         flg_start_r <= 8'h00;
      end
      else
      begin
         done_r <= 1'b0;
         case (state_r)
            sle_pkg::SLE_IDLE:
            begin
               if (start_i)
               begin
                  cmd_r <= cmd_i;
                  step_r <= 4'h0;
                  busy_r <= 1'b1;
                  flg_start_r <= flg;
                  state_r <= sle_pkg::SLE_RUN;
               end
            end
            sle_pkg::SLE_RUN:
            begin
               // a no-op simply runs out its cycles
               step_r <= step_r + 4'h1;
               if (last)
               begin
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
                  state_r <= sle_pkg::SLE_IDLE;
               end
            end
            default:
               state_r <= sle_pkg::SLE_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Memory, program and observation ports
   wire mem_rd = is_pop && step_r == 4'h0;
   // write lands after SP was lowered in step 0
   wire mem_wr = is_push && step_r == 4'h1;
   wire prg_rd = is_next && step_r == 4'h0;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_r <= '0;
         prog_re_r <= 1'b0;
         prog_addr_r <= 16'h0000;
         pc_r <= 16'h0000;
         dbg_r <= 8'h00;
      end
      else
      begin
         mem_r.re <= mem_rd;
         mem_r.we <= mem_wr;
         if (mem_rd || mem_wr)
            mem_r.addr <= sp_cur;
         if (mem_wr)
            mem_r.wdata <= src_val;
         prog_re_r <= prg_rd;
         if (prg_rd)
            prog_addr_r <= ip_cur;
         if (is_next && step_r == 4'h2)
            pc_r <= prog_rdata_i;
         dbg_r <= rf_q[dbg_addr_i];
      end
   end

   assign busy_o = busy_r;
   assign done_o = done_r;
   assign dbg_data_o = dbg_r;
   assign flags_o = rf_q[`SLE_ADR_FLG];
   assign pc_o = pc_r;
   assign mem_o = mem_r;
   assign prog_re_o = prog_re_r;
   assign prog_addr_o = prog_addr_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   wire flag_keep = (op != `SLE_OP_OR) && (op != `SLE_OP_NEXT);
   wire [7:0] pop_dst = cmd_r.dst;

   sequence pop_load_s;
      ##2 (we0 && wa0 == pop_dst && !we1);
   endsequence
   sequence pop_bump_s;
      ##1 (we0 && wa0 == `SLE_ADR_SPL && we1 && wa1 == `SLE_ADR_SPH);
   endsequence

   nop_no_write_a: assert property (
      (run && op == `SLE_OP_NOP) |-> !we0 && !we1 && !mem_r.we)
      else $error("no-op wrote state");
   flags_kept_a: assert property (
      done_r && flag_keep |-> flags_o == flg_start_r)
      else $error("flags changed by flag-neutral opcode");
   or_result_a: assert property (
      (is_or && step_r == 4'h0) |=>
         rf_q[pop_dst] == ($past(rf_q[pop_dst]) | $past(src_val)))
      else $error("OR result wrong");
   or_flags_a: assert property (
      (is_or && step_r == 4'h0) |=>
         flg[`SLE_FLG_Z] == (rf_q[pop_dst] == 8'h00) &&
         flg[`SLE_FLG_S] == rf_q[pop_dst][7] && !flg[`SLE_FLG_V] &&
         (flg & 8'h8C) == ($past(flg) & 8'h8C))
      else $error("OR flags wrong");
   pop_order_a: assert property (
      (is_pop && step_r == 4'h0) |-> pop_load_s ##0 pop_bump_s)
      else $error("pop order wrong");
   push_order_a: assert property (
      (is_push && step_r == 4'h0) |=> sp_cur == $past(sp_nxt) ##1
         (mem_r.we && mem_r.addr == sp_cur))
      else $error("push order wrong");
   sp_wrap_a: assert property (
      (is_push && step_r == 4'h0 && sp_cur == 16'h0000) |=>
         sp_cur == 16'hFFFF)
      else $error("stack pointer wrap wrong");
   upop_step_a: assert property (
      (is_upop && step_r == 4'h0 && !usp_up) |=>
         rf_q[usp_adr] == $past(usp_val) ##1
         rf_q[usp_adr] == $past(usp_val, 2) - 8'h01)
      else $error("decrementing user pop wrong");
   upopi_step_a: assert property (
      (is_upop && step_r == 4'h1 && usp_up) |=>
         rf_q[usp_adr] == $past(usp_val) + 8'h01)
      else $error("incrementing user pop wrong");
   upush_dn_a: assert property (
      (is_upsh && step_r == 4'h0 && !usp_up) |=>
         usp_val == $past(usp_val) - 8'h01 ##1
         rf_q[$past(usp_val)] == $past(src_val))
      else $error("decrementing user push wrong");
   upush_up_a: assert property (
      (is_upsh && step_r == 4'h0 && usp_up) |=>
         usp_val == $past(usp_val) + 8'h01)
      else $error("incrementing user push wrong");
   next_ip_a: assert property (
      (is_next && step_r == 4'h3) |=>
         ip_cur == $past(ip_cur) + 16'h0002 && pc_r == $past(pc_r))
      else $error("dispatch IP step wrong");
   usp_wrap_a: assert property (
      (is_upsh && step_r == 4'h0 && usp_up && usp_val == 8'hFF) |=>
         usp_val == 8'h00 && !we1)
      else $error("user pointer wrap wrong");
endmodule : sle_core

/* File: hw/sle_consts.svh */
// Constants for the stack and logic instruction executor.
// Assumes inclusion by bare name from the package and the core files.
`ifndef SLE_CONSTS_SVH
`define SLE_CONSTS_SVH

// Opcodes
`define SLE_OP_NOP    8'hFF
`define SLE_OP_OR     8'h42
`define SLE_OP_POP    8'h50
`define SLE_OP_PUSH   8'h70
`define SLE_OP_NEXT   8'h0F
`define SLE_OP_UPOPD  8'h92
`define SLE_OP_UPOPI  8'h93
`define SLE_OP_UPSHD  8'h82
`define SLE_OP_UPSHI  8'h83

// Execution times in CPU cycles
`define SLE_CYC_NOP   4'h4
`define SLE_CYC_OR    4'h4
`define SLE_CYC_STK   4'h8
`define SLE_CYC_NEXT  4'hA

// Register file locations
`define SLE_ADR_SPH   8'hDB
`define SLE_ADR_SPL   8'hD9
`define SLE_ADR_FLG   8'hD5
`define SLE_ADR_IPH   8'hDE
`define SLE_ADR_IPL   8'hDF

// Flag bit positions
`define SLE_FLG_C     7
`define SLE_FLG_Z     6
`define SLE_FLG_S     5
`define SLE_FLG_V     4
`define SLE_FLG_D     3
`define SLE_FLG_H     2
`define SLE_ZSV_MASK  8'h70

`define SLE_RST_BYTE  8'h00
`endif

/* File: hw/sle_pkg.sv */
// Types shared by the executor core and its bench.
// Assumes sle_consts.svh is on the include path.
`include "sle_consts.svh"
package sle_pkg;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] dst;
      logic [7:0] src;
      logic src_imm;
   } sle_cmd_s;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } sle_wr_s;

   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sle_mem_s;

   typedef enum logic {SLE_IDLE, SLE_RUN} sle_state_e;
endpackage : sle_pkg

/* File: hw/sle_step.sv */
// Wrapping up/down step of a pointer by a fixed amount.
// Assumes nothing; purely combinational.
`timescale 1ns/1ps
module sle_step #(
   parameter int W = 8,
   parameter int STEP = 1
) (
   input wire logic [W-1:0] val_i,
   input wire logic up_i,
   output logic [W-1:0] val_o
);
   localparam logic [W-1:0] AMT = W'(STEP);
   // Wraps modulo 2**W by construction
   assign val_o = up_i ? val_i + AMT : val_i - AMT;
endmodule : sle_step

/* File: sim/sle_core_tb.sv */
// Self-checking bench for the stack and logic instruction executor.
// Assumes sle_pkg and sle_core are compiled first; the bench plays the
// stack memory, the program memory and the host port itself.
`timescale 1ns/1ps
module sle_core_tb;
   logic clk_i;
   logic nrst_i;
   logic start_i;
   sle_pkg::sle_cmd_s cmd_i;
   sle_pkg::sle_wr_s host_wr_i;
   logic [7:0] dbg_addr_i;
   logic [7:0] mem_rdata_i;
   logic [15:0] prog_rdata_i;
   logic busy_o;
   logic done_o;
   logic [7:0] dbg_data_o;
   logic [7:0] flags_o;
   logic [15:0] pc_o;
   sle_pkg::sle_mem_s mem_o;
   logic prog_re_o;
   logic [15:0] prog_addr_o;
   int errors;
   int checked;
   int rf[256];
   int smem[int];
   int pcm;
   int unsigned seed;
   int uops[4] = '{8'h92, 8'h93, 8'h82, 8'h83};

   sle_core DUT (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i),
      .cmd_i(cmd_i), .host_wr_i(host_wr_i), .dbg_addr_i(dbg_addr_i),
      .mem_rdata_i(mem_rdata_i), .prog_rdata_i(prog_rdata_i),
      .busy_o(busy_o), .done_o(done_o), .dbg_data_o(dbg_data_o),
      .flags_o(flags_o), .pc_o(pc_o), .mem_o(mem_o),
      .prog_re_o(prog_re_o), .prog_addr_o(prog_addr_o));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

////////////////////////////////////////////////////////////////////////
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string what, input logic [23:0] seen,
      input int exp);
      checked++;
      if (seen !== exp[23:0])
      begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp[23:0], seen);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic wr(input int a, input int d);
      @(posedge clk_i);
      host_wr_i <= '{1'b1, a[7:0], d[7:0]};
      @(posedge clk_i);
      host_wr_i.we <= 1'b0;
      rf[a] = d % 256;
   endtask : wr

   // Whole register file against the model
   task automatic cmp_all();
      for (int a = 0; a < 256; a++)
      begin
         @(posedge clk_i);
         dbg_addr_i <= a[7:0];
         @(posedge clk_i);
         #1;
         chk("register", 24'(dbg_data_o), rf[a]);
      end
   endtask : cmp_all

////////////////////////////////////////////////////////////////////////
   // One instruction; poke tries a host write while busy
   task automatic exec(input int op, input int dst, input int src,
      input bit imm, input bit poke);
      int n, k, v, sp, ip, md, pd, f, nre, nwe, npr, ra, wa, pa, er, ew;
      int ep, ea, nb;
      bit rn;
      bit pn;
      v = imm ? src : rf[src];
      sp = rf[8'hDB] * 256 + rf[8'hD9];
      ip = rf[8'hDE] * 256 + rf[8'hDF];
      md = smem.exists(sp) ? smem[sp] : rnd() % 256;
      pd = rnd() % 65536;
      f = rf[8'hD5];
      {nre, nwe, npr, er, ew, ep, k, ra, wa, pa, ea, nb} = '0;
      rn = 1'b0;
      pn = 1'b0;
      n = 4;
      @(posedge clk_i);
      start_i <= 1'b1;
      cmd_i <= '{op[7:0], dst[7:0], src[7:0], imm};
      @(posedge clk_i);
      start_i <= 1'b0;
      host_wr_i <= '{poke, 8'h10, 8'h5A};
      #1;
      while (done_o !== 1'b1 && k < 20)
      begin
         @(posedge clk_i);
         host_wr_i.we <= 1'b0;
         mem_rdata_i <= rn ? md[7:0] : ~mem_rdata_i;
         prog_rdata_i <= pn ? pd[15:0] : ~prog_rdata_i;
         k++;
         #1;
         rn = (mem_o.re === 1'b1);
         pn = (prog_re_o === 1'b1);
         nre += rn;
         npr += pn;
         if (rn)
            ra = mem_o.addr;
         if (pn)
            pa = prog_addr_o;
         if (mem_o.we === 1'b1)
            wa = {mem_o.wdata, mem_o.addr};
         nwe += (mem_o.we === 1'b1);
         nb += (busy_o === 1'b1);
      end
      case (op)
         8'h42:
         begin
            v = v | rf[dst];
            rf[dst] = v;
            f = (f & 8'h8F) | (v == 0 ? 8'h40 : 0) | (v > 127 ? 8'h20 : 0);
            rf[8'hD5] = f;
         end
         8'h70:
         begin
            n = 8;
            sp = (sp + 65535) % 65536;
            ew = 1;
            ea = v * 65536 + sp;
            smem[sp] = v;
         end
         8'h50:
         begin
            n = 8;
            er = 1;
            ea = sp;
            rf[dst] = md;
            sp = (sp + 1) % 65536;
         end
         8'h92, 8'h93:
         begin
            n = 8;
            rf[dst] = rf[rf[src]];
            rf[src] = (rf[src] + (op == 8'h93 ? 1 : 255)) % 256;
         end
         8'h82, 8'h83:
         begin
            n = 8;
            rf[dst] = (rf[dst] + (op == 8'h83 ? 1 : 255)) % 256;
            rf[rf[dst]] = imm ? src : rf[src];
         end
         8'h0F:
         begin
            n = 10;
            ep = 1;
            ea = ip;
            pcm = pd;
            ip = (ip + 2) % 65536;
         end
         default:
            n = 4;
      endcase
      rf[8'hDB] = sp / 256;
      rf[8'hD9] = sp % 256;
      rf[8'hDE] = ip / 256;
      rf[8'hDF] = ip % 256;
      chk("cycles", k[23:0], n);
      chk("busy", nb[23:0], n - 1);
      chk("busy_end", 24'(busy_o), 0);
      chk("mem_re", nre[23:0], er);
      chk("mem_we", nwe[23:0], ew);
      chk("prog_re", npr[23:0], ep);
      if (er)
         chk("pop_addr", ra[23:0], ea);
      if (ew)
         chk("push_data_addr", wa[23:0], ea);
      if (ep)
         chk("prog_addr", pa[23:0], ea);
      chk("flags", 24'(flags_o), rf[8'hD5]);
      chk("pc", 24'(pc_o), pcm);
      cmp_all();
   endtask : exec

////////////////////////////////////////////////////////////////////////
   initial
   begin
      nrst_i = 1'b0;
      start_i = 1'b0;
      cmd_i = '0;
      host_wr_i = '0;
      dbg_addr_i = 8'h00;
      mem_rdata_i = 8'h00;
      prog_rdata_i = 16'h0000;
      errors = 0;
      checked = 0;
      seed = 33;
      pcm = 0;
      foreach (rf[i])
         rf[i] = 0;
      repeat (8) @(posedge clk_i);
      chk("reset_ctl", 24'({busy_o, done_o, mem_o.re, mem_o.we}), 0);
      chk("reset_pc", 24'(pc_o), 0);
      nrst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      for (int a = 0; a < 128; a++)
         wr(a, rnd() % 256);
      wr(8'hD5, rnd() % 256);
      $display("reset and seed test done");
      exec(8'hFF, 0, 0, 1'b1, 1'b1);
      exec(8'h01, 0, 0, 1'b1, 1'b1);
      $display("no-op and refusal test done");
      for (int i = 0; i < 12; i++)
         exec(8'h42, rnd() % 128, i[0] ? rnd() % 256 : rnd() % 128, i[0], 1'b0);
      wr(5, 0);
      exec(8'h42, 5, 0, 1'b1, 1'b0);
      $display("or test done");
      for (int i = 0; i < 8; i++)
         exec(i < 4 ? 8'h70 : 8'h50, 8'h20 + i,
            i[0] ? rnd() % 256 : rnd() % 128, i[0], 1'b0);
      wr(8'hDB, 8'hFF);
      wr(8'hD9, 8'hFF);
      exec(8'h50, 8'h28, 0, 1'b0, 1'b0);
      $display("system stack test done");
      for (int i = 0; i < 12; i++)
      begin
         wr(8'h30, i % 3 == 0 ? 0 : (i % 3 == 1 ? 255 : 8'h50));
         if (i < 6)
            exec(uops[i / 3], 8'h31, 8'h30, 1'b0, 1'b0);
         else
            exec(uops[i / 3], 8'h30, i[0] ? rnd() % 256 : 8'h33, i[0], 1'b0);
      end
      $display("user stack test done");
      wr(8'hDE, 8'hFF);
      wr(8'hDF, 8'hFE);
      repeat (2) exec(8'h0F, 0, 0, 1'b0, 1'b0);
      $display("dispatch test done");
      print_verdict();
   end

   initial
   begin
      #1_000_000;
      errors++;
      $display("ERROR watchdog expired");
      print_verdict();
   end
endmodule : sle_core_tb
